// >>> verilog/dsm_defines.svh
/*
  Register numbers, field positions and widths of the drive status monitor bank.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef DSM_DEFINES_SVH
`define DSM_DEFINES_SVH

`define DSM_ADDR_W        16
`define DSM_DATA_W        16
`define DSM_WIN_LO        16'h0029
`define DSM_WIN_HI        16'h003f
`define DSM_REG_SEQ_IN    16'h002b
`define DSM_REG_COND      16'h002c
`define DSM_REG_CONTACT   16'h002d
`define DSM_REG_DC_BUS    16'h0031
`define DSM_REG_TORQUE    16'h0032
`define DSM_REG_POWER     16'h0033
`define DSM_REG_PID_FB    16'h0038
`define DSM_REG_PID_IN    16'h0039
`define DSM_REG_PID_OUT   16'h003a
`define DSM_REG_CPU_SW    16'h003b
`define DSM_REG_FLASH_SW  16'h003c
`define DSM_REG_LINK_ERR  16'h003d
`define DSM_REG_KVA       16'h003e
`define DSM_REG_CTRL_MODE 16'h003f

`define DSM_SEQ_IN_W      12
`define DSM_CONTACT_W     5
`define DSM_LINK_ERR_W    7
`define DSM_LINK_ERR_MASK 7'h7b
`define DSM_COND_SPARE    2'h0
`define DSM_ZERO16        16'h0000
`define DSM_ZERO_ERR      7'h00
`define DSM_SYNC_ZERO_SEQ 12'h000
`define DSM_SYNC_ZERO_CON 5'h00

`endif

// >>> verilog/dsm_pkg.sv
/*
  Types of the drive status monitor bank: carriers for drive flags,
  analogue monitor words and one-cycle link error events.
  Assumes dsm_defines.svh is on the include path.
*/
`include "dsm_defines.svh"

package dsm_pkg;

  // ==========================================================
  // Drive condition inputs, one bit each
  typedef struct packed {
    logic link_timeout;
    logic any_fault;
    logic retrying;
    logic ref_lost;
    logic overtorque;
    logic run_src_local;
    logic freq_src_local;
    logic startup_done;
    logic freq_detect_2;
    logic freq_detect_1;
    logic user_speed_match;
    logic freq_match;
    logic zero_speed;
    logic running;
  } dsm_cond_t;

  // ==========================================================
  // Analogue monitor and identity words, already scaled upstream
  typedef struct packed {
    logic [15:0] dc_bus;
    logic [15:0] torque;
    logic [15:0] power;
    logic [15:0] pid_fb;
    logic [15:0] pid_in;
    logic [15:0] pid_out;
    logic [15:0] cpu_sw;
    logic [15:0] flash_sw;
    logic [15:0] kva;
    logic [15:0] ctrl_mode;
  } dsm_mon_t;

  // ==========================================================
  // One-cycle link error events from the frame receiver
  typedef struct packed {
    logic timeout;
    logic framing;
    logic overrun;
    logic parity;
    logic bad_length;
    logic crc;
  } dsm_err_evt_t;

  // ==========================================================
  // Read port request and answer
  typedef struct packed {
    logic        rd_en;
    logic [15:0] addr;
  } dsm_req_t;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [15:0] data;
  } dsm_rsp_t;

endpackage

// >>> verilog/dsm_sync.sv
/*
  Two-flop synchroniser for a bus of pin levels.
  Assumes the first stage is read only by the second.
*/
`timescale 1ns/1ps

module dsm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } dsm_sync_state_t;

  dsm_sync_state_t state_reg;
  dsm_sync_state_t state_next;

  always_comb
  begin
    state_next        = state_reg;
    state_next.stage1 = pin_in;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign level_out = state_reg.stage2;

endmodule

// >>> verilog/dsm_monitor_regs.sv
/*
  Drive status monitor register bank, registers 0029h to control_method_setting.
  Reads pin levels through synchronisers, drive flags and scaled monitor
  words from same-clock logic; latches link error events until fault reset.
  Assumes the link slave decodes frames and presents one read per request.
*/
`timescale 1ns/1ps

`include "dsm_defines.svh"

module dsm_monitor_regs (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic [11:0]            seq_input_pins,
  input  wire logic [2:0]             relay_output_state,
  input  wire logic                   photocoupler_output_3,
  input  wire logic                   photocoupler_output_4,
  input  wire dsm_pkg::dsm_cond_t     cond_in,
  input  wire dsm_pkg::dsm_mon_t      mon_in,
  input  wire dsm_pkg::dsm_err_evt_t  err_evt,
  input  wire logic                   fault_reset,
  input  wire logic                   wr_en,
  input  wire dsm_pkg::dsm_req_t      req,
  output dsm_pkg::dsm_rsp_t           rsp,
  output logic [6:0]                  link_err_latched
);

  // ==========================================================
  // Pin synchronisers
  logic [`DSM_SEQ_IN_W-1:0]  seq_sync;
  logic [`DSM_CONTACT_W-1:0] contact_sync;

  dsm_sync #(
    .W (`DSM_SEQ_IN_W)
  ) u_seq_sync (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .pin_in    (seq_input_pins),
    .level_out (seq_sync)
  );

  dsm_sync #(
    .W (`DSM_CONTACT_W)
  ) u_contact_sync (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .pin_in    ({photocoupler_output_4, photocoupler_output_3, relay_output_state}),
    .level_out (contact_sync)
  );

  // ==========================================================
  // State
  typedef struct packed {
    logic [`DSM_LINK_ERR_W-1:0] link_err;
    logic                       rsp_valid;
    logic                       rsp_hit;
    logic [`DSM_DATA_W-1:0]     rsp_data;
  } dsm_state_t;

  dsm_state_t state_reg;
  dsm_state_t state_next;

  // ==========================================================
  // Register images
  logic [`DSM_DATA_W-1:0]     seq_word;
  logic [`DSM_DATA_W-1:0]     cond_word;
  logic [`DSM_DATA_W-1:0]     contact_word;
  logic [`DSM_DATA_W-1:0]     err_word;
  logic [`DSM_LINK_ERR_W-1:0] err_set;

  always_comb
  begin
    seq_word     = {4'h0, seq_sync};
    contact_word = {11'h000, contact_sync};
    cond_word    = {cond_in.link_timeout,
                    cond_in.any_fault | cond_in.link_timeout,
                    cond_in.retrying,
                    cond_in.ref_lost,
                    cond_in.overtorque,
                    cond_in.run_src_local,
                    cond_in.freq_src_local,
                    `DSM_COND_SPARE,
                    cond_in.startup_done,
                    cond_in.freq_detect_2,
                    cond_in.freq_detect_1,
                    cond_in.user_speed_match,
                    cond_in.freq_match,
                    cond_in.zero_speed,
                    cond_in.running};
    err_set      = {err_evt.timeout, err_evt.framing, err_evt.overrun,
                    err_evt.parity, 1'b0, err_evt.bad_length, err_evt.crc};
    err_word     = {9'h000, state_reg.link_err};
  end

  // Read decode, used for hit and data
  function automatic logic [16:0] dsm_decode(input logic [15:0] a);
    logic [16:0] r;
    r = {1'b1, `DSM_ZERO16};
    unique case (a)
      `DSM_REG_SEQ_IN:    r[15:0] = seq_word;
      `DSM_REG_COND:      r[15:0] = cond_word;
      `DSM_REG_CONTACT:   r[15:0] = contact_word;
      `DSM_REG_DC_BUS:    r[15:0] = mon_in.dc_bus;
      `DSM_REG_TORQUE:    r[15:0] = mon_in.torque;
      `DSM_REG_POWER:     r[15:0] = mon_in.power;
      `DSM_REG_PID_FB:    r[15:0] = mon_in.pid_fb;
      `DSM_REG_PID_IN:    r[15:0] = mon_in.pid_in;
      `DSM_REG_PID_OUT:   r[15:0] = mon_in.pid_out;
      `DSM_REG_CPU_SW:    r[15:0] = mon_in.cpu_sw;
      `DSM_REG_FLASH_SW:  r[15:0] = mon_in.flash_sw;
      `DSM_REG_LINK_ERR:  r[15:0] = err_word;
      `DSM_REG_KVA:       r[15:0] = mon_in.kva;
      `DSM_REG_CTRL_MODE: r[15:0] = mon_in.ctrl_mode;
      default:
      begin
        // Unused slots inside the window read zero; outside is a miss
        r[16] = (a >= `DSM_WIN_LO) && (a <= `DSM_WIN_HI);
      end
    endcase
    return r;
  endfunction

  // ==========================================================
  // Next state
  logic [16:0] dec;

  always_comb
  begin
    dec        = dsm_decode(req.addr);
    state_next = state_reg;
    // Set wins over the clearing fault reset
    if (fault_reset)
    begin
      state_next.link_err = err_set;
    end
    else
    begin
      state_next.link_err = state_reg.link_err | err_set;
    end
    // Writes are ignored: wr_en never reaches any state
    state_next.rsp_valid = req.rd_en;
    state_next.rsp_hit   = req.rd_en & dec[16];
    state_next.rsp_data  = (req.rd_en & dec[16]) ? dec[15:0] : `DSM_ZERO16;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  // One driver for the whole answer struct
  assign rsp              = '{valid: state_reg.rsp_valid,
                              hit:   state_reg.rsp_hit,
                              data:  state_reg.rsp_data};
  assign link_err_latched = state_reg.link_err;

  logic unused_wr;
  assign unused_wr = wr_en;

endmodule

// >>> testbench/dsm_checker.sv
/* Port assertions for the monitor bank.
   Assumes bind onto dsm_monitor_regs below. */
`timescale 1ns/1ps
module dsm_checker (
  input wire logic                 clk_sys,
  input wire logic                 reset_n,
  input wire logic [11:0]          seq_input_pins,
  input wire logic [2:0]           relay_output_state,
  input wire logic                 photocoupler_output_3,
  input wire logic                 photocoupler_output_4,
  input wire dsm_pkg::dsm_cond_t   cond_in,
  input wire dsm_pkg::dsm_mon_t    mon_in,
  input wire dsm_pkg::dsm_err_evt_t err_evt,
  input wire logic                 fault_reset,
  input wire logic                 wr_en,
  input wire dsm_pkg::dsm_req_t    req,
  input wire dsm_pkg::dsm_rsp_t    rsp,
  input wire logic [6:0]           link_err_latched
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // ==========
  // Read port
  a_rsp_follows: assert property (req.rd_en |=> rsp.valid) else $error("no answer");
  a_rsp_spurious: assert property (!req.rd_en |=> !rsp.valid) else $error("extra answer");
  a_miss_zero: assert property (req.rd_en && (req.addr < 16'h0029 || req.addr > 16'h003f)
    |=> !rsp.hit && rsp.data == 16'h0000) else $error("miss not zero");
  a_cond_word: assert property (req.rd_en && req.addr == 16'h002c |=> rsp.data ==
    {$past(cond_in[13]), $past(cond_in[13] | cond_in[12]), $past(cond_in[11:7]), 2'h0,
    $past(cond_in[6:0])}) else $error("condition word");
  a_seq_top: assert property (req.rd_en && req.addr == 16'h002b
    |=> rsp.data[15:12] == 4'h0) else $error("input top bits");
  a_contact_top: assert property (req.rd_en && req.addr == 16'h002d
    |=> rsp.data[15:5] == 11'h000) else $error("contact top bits");
  // ==========
  // Link error latch
  a_err_set: assert property (err_evt != 6'h00 |=> (link_err_latched &
    {$past(err_evt[5:2]), 1'b0, $past(err_evt[1:0])}) ==
    {$past(err_evt[5:2]), 1'b0, $past(err_evt[1:0])}) else $error("error not latched");
  a_err_hold: assert property (!fault_reset |=> (link_err_latched & $past(link_err_latched))
    == $past(link_err_latched)) else $error("error lost");
  a_err_clear: assert property (fault_reset && err_evt == 6'h00
    |=> link_err_latched == 7'h00) else $error("error not cleared");
endmodule
bind dsm_monitor_regs dsm_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .seq_input_pins(seq_input_pins), .relay_output_state(relay_output_state),
  .photocoupler_output_3(photocoupler_output_3), .photocoupler_output_4(photocoupler_output_4),
  .cond_in(cond_in), .mon_in(mon_in), .err_evt(err_evt), .fault_reset(fault_reset),
  .wr_en(wr_en), .req(req), .rsp(rsp), .link_err_latched(link_err_latched));

// >>> testbench/dsm_master.sv
/* Link master model reading register bursts.
   Assumes calls start just after a rising edge. */
`timescale 1ns/1ps
module dsm_master (
  input  wire logic              clk_sys,
  output dsm_pkg::dsm_req_t      req,
  input  wire dsm_pkg::dsm_rsp_t rsp
);
  dsm_pkg::dsm_rsp_t ans [16];
  initial req = '{rd_en: 1'b0, addr: 16'h5a5a};
  task automatic burst(input logic [15:0] start, input int n);
    int i;
    if (n < 1 || n > 16)
      return;
    for (i = 0; i < n; i++)
    begin
      req <= '{rd_en: 1'b1, addr: start + 16'(i)};
      @(posedge clk_sys);
      #1;
      ans[i] = rsp;
    end
    req <= '{rd_en: 1'b0, addr: ~req.addr};
    @(posedge clk_sys);
    #1;
  endtask
endmodule

// >>> testbench/tb.sv
/* Self-checking bench for the monitor bank.
   Assumes the master model and the bound checker. */
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] pins = 12'h000;
  logic [2:0] relay = 3'h0;
  logic pc3 = 1'b0;
  logic pc4 = 1'b0;
  logic fault_reset = 1'b0;
  logic wr_en = 1'b0;
  logic [6:0] exp_err = 7'h00;
  logic [6:0] err_lat;
  dsm_pkg::dsm_cond_t cond = '0;
  dsm_pkg::dsm_mon_t mon = {16'hc031, 16'hc032, 16'hc033, 16'hc038, 16'hc039,
    16'hc03a, 16'hc03b, 16'hc03c, 16'hc03e, 16'hc03f};
  dsm_pkg::dsm_err_evt_t evt = '0;
  dsm_pkg::dsm_req_t req;
  dsm_pkg::dsm_rsp_t rsp;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  always #5 clk_sys = ~clk_sys;
  dsm_monitor_regs dut (.clk_sys(clk_sys), .reset_n(reset_n), .seq_input_pins(pins),
    .relay_output_state(relay), .photocoupler_output_3(pc3), .photocoupler_output_4(pc4),
    .cond_in(cond), .mon_in(mon), .err_evt(evt), .fault_reset(fault_reset), .wr_en(wr_en),
    .req(req), .rsp(rsp), .link_err_latched(err_lat));
  dsm_master m (.clk_sys(clk_sys), .req(req), .rsp(rsp));
  // ==========
  // Helpers
  task automatic cyc(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [16:0] exp_word(input logic [15:0] a);
    if (a < 16'h0029 || a > 16'h003f)
      return 17'h00000;
    case (a)
      16'h002b: return {5'h10, pins};
      16'h002c: return {1'b1, cond[13], cond[13] | cond[12], cond[11:7], 2'h0, cond[6:0]};
      16'h002d: return {12'h800, pc4, pc3, relay};
      16'h003d: return {10'h200, exp_err};
      16'h0029, 16'h002a, 16'h002e, 16'h002f, 16'h0030, 16'h0034, 16'h0035, 16'h0036,
        16'h0037: return 17'h10000;
      default: return {1'b1, 16'hc000 | a};
    endcase
  endfunction
  task automatic rd_chk(input logic [15:0] a, input int n);
    int i;
    m.burst(a, n);
    for (i = 0; i < n; i++)
    begin
      chk({16'h0000, m.ans[i].valid}, 17'h00001);
      chk({m.ans[i].hit, m.ans[i].data}, exp_word(a + 16'(i)));
    end
  endtask
  // ==========
  // Scenarios
  task automatic t_pins();
    pins = 12'ha5c;
    relay = 3'h5;
    pc3 = 1'b1;
    cond = 14'h1555;
    cyc(3);
    rd_chk(16'h002b, 3);
    pins = 12'h5a3;
    relay = 3'h2;
    pc3 = 1'b0;
    pc4 = 1'b1;
    cond = 14'h2aaa;
    cyc(3);
    rd_chk(16'h002b, 3);
  endtask
  task automatic t_map();
    wr_en = 1'b1;
    rd_chk(16'h0029, 16);
    rd_chk(16'h0038, 8);
    rd_chk(16'h0028, 1);
    rd_chk(16'h0040, 1);
    wr_en = 1'b0;
  endtask
  task automatic t_err();
    int i;
    cond = 14'h0001;
    for (i = 0; i < 6; i++)
    begin
      evt = 6'(1 << i);
      cyc(1);
      evt = '0;
      exp_err[i < 2 ? i : i + 1] = 1'b1;
      chk({10'h0, err_lat}, {10'h0, exp_err});
    end
    cyc(4);
    rd_chk(16'h003d, 1);
    fault_reset = 1'b1;
    cyc(1);
    fault_reset = 1'b0;
    exp_err = 7'h00;
    rd_chk(16'h003d, 1);
    evt = 6'h01;
    fault_reset = 1'b1;
    cyc(1);
    evt = '0;
    fault_reset = 1'b0;
    exp_err = 7'h01;
    chk({10'h0, err_lat}, {10'h0, exp_err});
    fault_reset = 1'b1;
    cyc(1);
    fault_reset = 1'b0;
    exp_err = 7'h00;
    chk({10'h0, err_lat}, {10'h0, exp_err});
  endtask
  task automatic final_report();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      final_report();
    end
  end
  initial
  begin
    cyc(10);
    reset_n = 1'b1;
    cyc(1);
    t_pins();
    t_map();
    t_err();
    final_report();
  end
endmodule
